/* core/exec_pkg.sv */
// shared constants, types and decode for the call and clear instruction executor
package exec_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int INSTR_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int FILE_ADDR_W = 7;
	localparam int FILE_DEPTH = 128;
	localparam int STACK_DEPTH = 8;
	localparam int APB_ADDR_W = 8;
	localparam int APB_DATA_W = 32;
	localparam int PRESCALE_W = 8;
	localparam int WDOG_W = 8;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [APB_ADDR_W-1:0] OFF_INSTR = 8'h00;
	localparam logic [APB_ADDR_W-1:0] OFF_PC = 8'h04;
	localparam logic [APB_ADDR_W-1:0] OFF_LATCH = 8'h08;
	localparam logic [APB_ADDR_W-1:0] OFF_STACK = 8'h0C;
	localparam logic [APB_ADDR_W-1:0] OFF_ACC = 8'h10;
	localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 8'h14;
	localparam logic [APB_ADDR_W-1:0] OFF_WDOG = 8'h18;
	localparam logic [APB_ADDR_W-1:0] OFF_FADDR = 8'h1C;
	localparam logic [APB_ADDR_W-1:0] OFF_FDATA = 8'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ST_ZERO_BIT = 0;
	localparam int ST_POWERDOWN_BIT = 3;
	localparam int ST_TIMEOUT_BIT = 4;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_LEVEL_LO = 8;
	localparam int LATCH_PAGE_HI = 4;
	localparam int LATCH_PAGE_LO = 3;
	localparam int WDOG_PRE_LO = 8;

	// ----------------------------------------------------------------
	// reset values and steps
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [APB_DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
	localparam logic FLAG_N_RST = 1'b1;
	localparam int CALL_CYCLES = 2;

	// ----------------------------------------------------------------
	// instruction encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] CALL_TOP = 3'h4;
	localparam logic [6:0] CLEAR_FILE_TOP = 7'h03;
	localparam logic [6:0] CLEAR_ACC_TOP = 7'h02;
	localparam logic [INSTR_W-1:0] CLEAR_DOG_CODE = 14'h0064;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_CALL = 3'h1,
		OP_CLEAR_FILE = 3'h2,
		OP_CLEAR_ACC = 3'h3,
		OP_CLEAR_DOG = 3'h4
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CALL = 2'b10
	} exec_state_t;

	function automatic op_t decode_op(input logic [INSTR_W-1:0] word);
		if (word[13:11] == CALL_TOP) begin
			return OP_CALL;
		end else if (word[13:7] == CLEAR_FILE_TOP) begin
			return OP_CLEAR_FILE;
		end else if (word[13:7] == CLEAR_ACC_TOP) begin
			return OP_CLEAR_ACC;
		end else if (word == CLEAR_DOG_CODE) begin
			return OP_CLEAR_DOG;
		end
		return OP_NONE;
	endfunction

endpackage

/* core/return_stack.sv */
// circular hardware return stack, push side only
`timescale 1ns/1ps
module return_stack import exec_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = PC_W
) (
	input wire logic pclk, // core clock
	input wire logic presetn, // async reset, active low
	input wire logic push, // one-cycle push strobe
	input wire logic [WIDTH-1:0] push_data, // address to push
	output logic [WIDTH-1:0] top, // entry most recently pushed
	output logic [$clog2(DEPTH)-1:0] level // write pointer
);

	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	logic [WIDTH-1:0] entries [DEPTH];
	logic [WIDTH-1:0] next_entries [DEPTH];
	logic [PTR_W-1:0] ptr;
	logic [PTR_W-1:0] next_ptr;

	// overflow wraps and overwrites the oldest entry, no error is raised
	always_comb begin
		next_entries = entries;
		next_ptr = ptr;
		if (push) begin
			next_entries[ptr] = push_data;
			next_ptr = ptr + PTR_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				entries[i] <= '0;
			end
		end else begin
			ptr <= next_ptr;
			entries <= next_entries;
		end
	end

	assign top = entries[ptr - PTR_ONE];
	assign level = ptr;

endmodule

/* core/call_and_clear_exec.sv */
// executor for call, clear-file, clear-accumulator and clear-watchdog, behind an apb slave
`timescale 1ns/1ps
// Contract
// - decode call when top three instruction bits are 100, 11-bit target
// - call first pushes program counter plus one onto the return stack
// - call loads the 11-bit target into program counter bits 10:0
// - call takes bits 12:11 from latch bits 4:3 and lasts two cycles
// - clear-file writes 00h to the addressed register and sets zero, one cycle
module call_and_clear_exec import exec_pkg::*; (
	input wire logic pclk, // core clock, 250 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [APB_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [APB_DATA_W-1:0] pwdata, // apb write data
	output logic [APB_DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr // apb error, unmapped address
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	exec_state_t state;
	exec_state_t next_state;
	logic [PC_W-1:0] program_counter;
	logic [PC_W-1:0] next_program_counter;
	logic [DATA_W-1:0] pc_high_latch;
	logic [DATA_W-1:0] next_pc_high_latch;
	logic [10:0] call_target;
	logic [10:0] next_call_target;
	logic [DATA_W-1:0] accumulator;
	logic [DATA_W-1:0] next_accumulator;
	logic zero_flag;
	logic next_zero_flag;
	logic timeout_flag_n;
	logic next_timeout_flag_n;
	logic powerdown_flag_n;
	logic next_powerdown_flag_n;
	logic [PRESCALE_W-1:0] prescaler;
	logic [PRESCALE_W-1:0] next_prescaler;
	logic [WDOG_W-1:0] watchdog_counter;
	logic [WDOG_W-1:0] next_watchdog_counter;
	logic [DATA_W-1:0] file_regs [FILE_DEPTH];
	logic [DATA_W-1:0] next_file_regs [FILE_DEPTH];
	logic [FILE_ADDR_W-1:0] file_addr;
	logic [FILE_ADDR_W-1:0] next_file_addr;
	logic [APB_DATA_W-1:0] next_prdata;
	logic next_pslverr;

	logic [PC_W-1:0] stack_top_entry;
	logic [$clog2(STACK_DEPTH)-1:0] stack_level;
	logic push;
	logic clear_file_reg_op;
	logic clear_accumulator_op;
	logic clear_dog_timer_op;
	logic reg_wr;
	logic exec_fire;
	op_t op;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// every write stalls while the call's second cycle runs, so the pc,
	// the latch and the file cannot be written under the call's feet
	assign pready = !(psel && penable && pwrite && state == ST_CALL);
	assign reg_wr = psel && penable && pwrite && pready;
	assign exec_fire = reg_wr && paddr == OFF_INSTR;
	assign op = decode_op(pwdata[INSTR_W-1:0]);
	assign clear_file_reg_op = exec_fire && op == OP_CLEAR_FILE;
	assign clear_accumulator_op = exec_fire && op == OP_CLEAR_ACC;
	assign clear_dog_timer_op = exec_fire && op == OP_CLEAR_DOG;

	function automatic logic addr_mapped(input logic [APB_ADDR_W-1:0] a);
		case (a)
			OFF_INSTR, OFF_PC, OFF_LATCH, OFF_STACK, OFF_ACC, OFF_STATUS,
			OFF_WDOG, OFF_FADDR, OFF_FDATA: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// return stack
	// ----------------------------------------------------------------
	return_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_W)
	) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.push(push),
		.push_data(program_counter + PC_STEP),
		.top(stack_top_entry),
		.level(stack_level)
	);

	// ----------------------------------------------------------------
	// sequencer, program counter and flags
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_program_counter = program_counter;
		next_pc_high_latch = pc_high_latch;
		next_call_target = call_target;
		next_accumulator = accumulator;
		next_zero_flag = zero_flag;
		next_timeout_flag_n = timeout_flag_n;
		next_powerdown_flag_n = powerdown_flag_n;
		push = 1'b0;
		case (state)
			ST_IDLE: begin
				if (exec_fire) begin
					case (op)
						OP_CALL: begin
							push = 1'b1;
							next_call_target = pwdata[10:0];
							next_state = ST_CALL;
						end
						OP_CLEAR_FILE: begin
							next_zero_flag = 1'b1;
							next_program_counter = program_counter + PC_STEP;
						end
						OP_CLEAR_ACC: begin
							next_accumulator = BYTE_ZERO;
							next_zero_flag = 1'b1;
							next_program_counter = program_counter + PC_STEP;
						end
						OP_CLEAR_DOG: begin
							next_timeout_flag_n = 1'b1;
							next_powerdown_flag_n = 1'b1;
							next_program_counter = program_counter + PC_STEP;
						end
						default: begin
							next_program_counter = program_counter + PC_STEP;
						end
					endcase
				end else if (reg_wr) begin
					case (paddr)
						OFF_PC: next_program_counter = pwdata[PC_W-1:0];
						OFF_LATCH: next_pc_high_latch = pwdata[DATA_W-1:0];
						OFF_ACC: next_accumulator = pwdata[DATA_W-1:0];
						OFF_STATUS: next_zero_flag = pwdata[ST_ZERO_BIT];
						default: begin
						end
					endcase
				end
			end
			ST_CALL: begin
				// page bits come from the latch, target from the word
				next_program_counter = {pc_high_latch[LATCH_PAGE_HI:LATCH_PAGE_LO],
					call_target};
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			program_counter <= PC_RST;
			pc_high_latch <= BYTE_ZERO;
			call_target <= '0;
			accumulator <= BYTE_ZERO;
			zero_flag <= 1'b0;
			timeout_flag_n <= FLAG_N_RST;
			powerdown_flag_n <= FLAG_N_RST;
		end else begin
			state <= next_state;
			program_counter <= next_program_counter;
			pc_high_latch <= next_pc_high_latch;
			call_target <= next_call_target;
			accumulator <= next_accumulator;
			zero_flag <= next_zero_flag;
			timeout_flag_n <= next_timeout_flag_n;
			powerdown_flag_n <= next_powerdown_flag_n;
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter and prescaler
	// ----------------------------------------------------------------
	// free-running count only; nothing in the core detects a timeout or clears timeout_flag_n
	always_comb begin
		next_prescaler = prescaler + PRESCALE_W'(1);
		next_watchdog_counter = watchdog_counter;
		if (&prescaler) begin
			next_watchdog_counter = watchdog_counter + WDOG_W'(1);
		end
		if (clear_dog_timer_op) begin
			next_prescaler = '0;
			next_watchdog_counter = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler <= '0;
			watchdog_counter <= '0;
		end else begin
			prescaler <= next_prescaler;
			watchdog_counter <= next_watchdog_counter;
		end
	end

	// ----------------------------------------------------------------
	// data file
	// ----------------------------------------------------------------
	always_comb begin
		next_file_regs = file_regs;
		next_file_addr = file_addr;
		if (clear_file_reg_op) begin
			next_file_regs[pwdata[FILE_ADDR_W-1:0]] = BYTE_ZERO;
		end else if (reg_wr && paddr == OFF_FDATA) begin
			next_file_regs[file_addr] = pwdata[DATA_W-1:0];
		end else if (reg_wr && paddr == OFF_FADDR) begin
			next_file_addr = pwdata[FILE_ADDR_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			file_addr <= '0;
			for (int i = 0; i < FILE_DEPTH; i++) begin
				file_regs[i] <= BYTE_ZERO;
			end
		end else begin
			file_addr <= next_file_addr;
			file_regs <= next_file_regs;
		end
	end

	// ----------------------------------------------------------------
	// read path, sampled in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (psel && !penable) begin
			next_prdata = WORD_ZERO;
			next_pslverr = !addr_mapped(paddr);
			case (paddr)
				OFF_PC: next_prdata[PC_W-1:0] = program_counter;
				OFF_LATCH: next_prdata[DATA_W-1:0] = pc_high_latch;
				OFF_STACK: next_prdata[PC_W-1:0] = stack_top_entry;
				OFF_ACC: next_prdata[DATA_W-1:0] = accumulator;
				OFF_STATUS: begin
					next_prdata[ST_ZERO_BIT] = zero_flag;
					next_prdata[ST_POWERDOWN_BIT] = powerdown_flag_n;
					next_prdata[ST_TIMEOUT_BIT] = timeout_flag_n;
					next_prdata[ST_BUSY_BIT] = state == ST_CALL;
					next_prdata[ST_LEVEL_LO +: $clog2(STACK_DEPTH)] = stack_level;
				end
				OFF_WDOG: begin
					next_prdata[WDOG_W-1:0] = watchdog_counter;
					next_prdata[WDOG_PRE_LO +: PRESCALE_W] = prescaler;
				end
				OFF_FADDR: next_prdata[FILE_ADDR_W-1:0] = file_addr;
				OFF_FDATA: next_prdata[DATA_W-1:0] = file_regs[file_addr];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= WORD_ZERO;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_CALL_DECODE: assert property (
		exec_fire && pwdata[13:11] == 3'h4 |=> state == ST_CALL && call_target == $past(pwdata[10:0])
	) else $error("call word not decoded");

	AST_CALL_PUSH: assert property (
		exec_fire && op == OP_CALL |=> stack_top_entry == $past(program_counter) + PC_STEP
	) else $error("return address not pushed");

	AST_CALL_TARGET: assert property (
		exec_fire && op == OP_CALL |=> ##1 program_counter[10:0] == $past(pwdata[10:0], 2)
	) else $error("call target not loaded");

	AST_CALL_PAGE: assert property (
		exec_fire && op == OP_CALL |=> ##1 program_counter[12:11] == $past(pc_high_latch[4:3], 2)
	) else $error("page bits not taken from latch");

	AST_CALL_TWO_CYCLES: assert property (
		exec_fire && op == OP_CALL |=> state == ST_CALL ##1 state == ST_IDLE
	) else $error("call not two cycles");

	AST_CALL_STALL: assert property (
		psel && penable && pwrite && state == ST_CALL |-> !pready
	) else $error("write accepted during call");

	AST_CLEAR_FILE: assert property (
		clear_file_reg_op |=> file_regs[$past(pwdata[6:0])] == 8'h00 && zero_flag
			&& program_counter == $past(program_counter) + PC_STEP && state == ST_IDLE
	) else $error("clear file failed");

	AST_CLEAR_ACC: assert property (
		clear_accumulator_op |=> accumulator == 8'h00 && zero_flag && state == ST_IDLE
	) else $error("clear accumulator failed");

	AST_CLEAR_DOG: assert property (
		clear_dog_timer_op |=> watchdog_counter == 8'h00 && prescaler == 8'h00
			&& timeout_flag_n && powerdown_flag_n
	) else $error("watchdog clear failed");

endmodule

/* dv/test_call_and_clear_exec.sv */
// self-checking testbench for the call and clear instruction executor
`timescale 1ns/1ps
module test_call_and_clear_exec import exec_pkg::*;;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_ADDR_W-1:0] paddr = 8'h00;
	logic [APB_DATA_W-1:0] pwdata = 32'h0000_0000;
	logic [APB_DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	note_t notes[$];
	note_t nt;
	int n_errors = 0;
	int checks_done = 0;
	int acc_n = 0;
	integer seed = 32'h3d90_a10b;
	logic [PC_W-1:0] pc_m;
	logic [PC_W-1:0] stk_m;
	logic [2:0] lvl_m;
	logic [10:0] k;
	logic [7:0] lat;
	logic [6:0] f;

	call_and_clear_exec call_and_clear_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	always #2 pclk = ~pclk;

	// ----------------------------------------------------------------
	// compare and report
	// ----------------------------------------------------------------
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got 0x%h exp 0x%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t err got 0x%h exp 0x%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// apb master: request held until pready is sampled high
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] e, input logic [31:0] m, input logic er);
		notes.push_back('{e, m, er});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no answer time is assumed; a slave that never answers is caught by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000, e, 32'hffff_ffff, 1'b0);
	endtask

	task automatic idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask

	function automatic logic [31:0] st(input logic z, input logic b, input logic [2:0] l);
		return {21'h00_0000, l, b, 2'b00, 1'b1, 1'b1, 2'b00, z};
	endfunction

	// ----------------------------------------------------------------
	// monitor: every completed transfer consumes the oldest note
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1) begin
			acc_n = acc_n + 1;
			if (pready === 1'b1) begin
				if (notes.size() == 0) begin
					n_errors++;
					$display("[FAIL] t=%0t stray 0x%h exp 0x%h", $time, prdata, 32'h0000_0000);
				end else begin
					nt = notes.pop_front();
					cmp_word(prdata & nt.m, nt.d & nt.m);
					cmp_bit(pslverr, nt.e);
					// writes never follow a call closely enough to overlap its second cycle
					cmp_word(32'(acc_n), 32'h0000_0001);
				end
				acc_n = 0;
			end
		end
	end

	initial begin
		repeat (10000) @(posedge pclk);
		n_errors++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFF_PC, WORD_ZERO);
		rd(OFF_STATUS, st(1'b0, 1'b0, 3'h0));
		rd(OFF_ACC, WORD_ZERO);
		rd(OFF_LATCH, WORD_ZERO);
		rd(OFF_STACK, WORD_ZERO);
		$display("test reset done");
		lvl_m = 3'h0;
		for (int i = 0; i < 10; i++) begin
			k = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($random(seed));
			lat = 8'($random(seed));
			pc_m = 13'($random(seed));
			wr(OFF_LATCH, {24'h00_0000, lat});
			wr(OFF_PC, {19'h0_0000, pc_m});
			wr(OFF_INSTR, {18'h0_0000, CALL_TOP, k});
			lvl_m = lvl_m + 3'h1;
			rd(OFF_STATUS, st(1'b0, 1'b1, lvl_m));
			stk_m = pc_m + PC_STEP;
			pc_m = {lat[LATCH_PAGE_HI:LATCH_PAGE_LO], k};
			rd(OFF_PC, {19'h0_0000, pc_m});
			rd(OFF_STACK, {19'h0_0000, stk_m});
		end
		$display("test call done");
		for (int i = 0; i < 3; i++) begin
			f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($random(seed));
			wr(OFF_FADDR, {25'h000_0000, f ^ 7'h01});
			wr(OFF_FDATA, 32'h0000_005a);
			wr(OFF_FADDR, {25'h000_0000, f});
			wr(OFF_FDATA, {24'h00_0000, 8'($random(seed)) | 8'h01});
			wr(OFF_STATUS, WORD_ZERO);
			wr(OFF_INSTR, {18'h0_0000, CLEAR_FILE_TOP, f});
			pc_m = pc_m + PC_STEP;
			rd(OFF_FDATA, WORD_ZERO);
			rd(OFF_STATUS, st(1'b1, 1'b0, lvl_m));
			rd(OFF_PC, {19'h0_0000, pc_m});
			wr(OFF_FADDR, {25'h000_0000, f ^ 7'h01});
			rd(OFF_FDATA, 32'h0000_005a);
		end
		$display("test clear file done");
		for (int i = 0; i < 2; i++) begin
			wr(OFF_ACC, {24'h00_0000, 8'($random(seed)) | 8'h80});
			wr(OFF_STATUS, WORD_ZERO);
			wr(OFF_INSTR, {18'h0_0000, CLEAR_ACC_TOP, 7'($random(seed))});
			pc_m = pc_m + PC_STEP;
			rd(OFF_ACC, WORD_ZERO);
			rd(OFF_STATUS, st(1'b1, 1'b0, lvl_m));
		end
		$display("test clear accumulator done");
		idle(600);
		wr(OFF_INSTR, {18'h0_0000, CLEAR_DOG_CODE});
		pc_m = pc_m + PC_STEP;
		// the prescaler restarts at once, so only the counter and top bits are exact
		xfer(1'b0, OFF_WDOG, WORD_ZERO, WORD_ZERO, 32'hffff_f8ff, 1'b0);
		rd(OFF_STATUS, st(1'b1, 1'b0, lvl_m));
		rd(OFF_PC, {19'h0_0000, pc_m});
		$display("test clear watchdog done");
		wr(OFF_INSTR, 32'h0000_3fff);
		pc_m = pc_m + PC_STEP;
		rd(OFF_PC, {19'h0_0000, pc_m});
		xfer(1'b0, 8'h24, WORD_ZERO, WORD_ZERO, 32'hffff_ffff, 1'b1);
		xfer(1'b1, 8'hfc, 32'h0000_1234, WORD_ZERO, 32'h0000_0000, 1'b1);
		wr(OFF_STACK, 32'h0000_1fff);
		rd(OFF_STACK, {19'h0_0000, stk_m});
		idle(4);
		$display("test refusals done");
		if (notes.size() != 0) begin
			n_errors++;
			$display("[FAIL] t=%0t pending 0x%h exp 0x%h", $time, notes.size(), 0);
		end
		report_and_stop();
	end
endmodule
